// ---- mgc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module mgc_host
(
  input wire logic clk,
  input wire logic miso,
  output logic sclk,
  output logic mosi,
  output logic select_n,
  output logic meas_reset
);
  initial {sclk, mosi, select_n, meas_reset} = 4'h2;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse_reset();
    select_n = 1'b0;
    tick(8);
    meas_reset = 1'b1;
    tick(10);
    meas_reset = 1'b0;
    tick(8);
  endtask
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      mosi = b[i];
      tick(6);
      sclk = 1'b1;
      tick(6);
      sclk = 1'b0;
    end
    tick(6);
    mosi = ~mosi;
  endtask
  // result bits are taken while the serial clock is high
  task automatic read16(output logic [15:0] v);
    v = 16'h0000;
    for (int i = 15; i >= 0; i--)
    begin
      tick(6);
      sclk = 1'b1;
      v[i] = miso;
      tick(6);
      sclk = 1'b0;
    end
    tick(6);
  endtask
endmodule
`default_nettype wire

// ---- mgc_pkg.sv ----
package mgc_pkg;
  localparam int CMD_W = 8;
  localparam int RES_W = 16;
  localparam int BIT_FAST_TEST = 7;
  localparam int BIT_PS_HI = 6;
  localparam int BIT_PS_LO = 4;
  localparam int BIT_DIR = 3;
  localparam int BIT_OSC_TEST = 2;
  localparam int BIT_AXIS_HI = 1;
  localparam int BIT_AXIS_LO = 0;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [1:0] AXIS_NONE = 2'h0;
  localparam logic [1:0] AXIS_X = 2'h1;
  localparam logic [1:0] AXIS_Y = 2'h2;
  localparam logic [1:0] AXIS_Z = 2'h3;
  localparam int DIV_BASE_LOG2 = 5;
  localparam int DIV_MAX_LOG2 = 12;
  typedef enum logic [4:0] {
    ST_POWERUP = 5'h01,
    ST_CMD = 5'h02,
    ST_FWD = 5'h04,
    ST_REV = 5'h08,
    ST_READY = 5'h10
  } mgc_state_t;
endpackage

// ---- mgc_sensor.sv ----
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RQ1: host runs the serial clock idle low, polarity zero only.
// RQ2: data sampled on rising clock edge; output changes on falling edge.
// RQ3: after power-up not idle; idle only entered from data-ready.
// RQ4: host lowers select, pulses reset, then sends one axis command.
// RQ5: command accepted and select high puts device in low power idle; code sets idle only in ST_READY, while select is high.
// RQ6: result_ready rises when result exists; reading it is optional.
// RQ7: one axis measured per command, chosen by axis field.
// RQ8: result is forward minus reverse count, 16-bit two's complement.
// RQ9: command byte fields: test out, period, direction, test run, axis.
// RQ10: test out bit drives fast clock div two, else pad held high.
// RQ11: period select sets divider 32 doubling up to 4096.
// RQ12: direction bit used only while oscillator test run is set.
// RQ13: test run keeps selected oscillator running until next reset.
// RQ14: axis codes 01 X, 10 Y, 11 external Z.
// RQ15: command executes after eight bits received, msb first.
// RQ16: after result_ready, result shifts out over next sixteen clocks.
// RQ17: host pulses reset before every measurement command.
// RQ18: slave output is high impedance whenever select is high; miso_oe_n follows select three clocks late and is low during reset.
// RQ19: axis code 00 starts nothing and leaves result_ready low.
// RQ20: reset pulse clears result_ready until result is available.
module mgc_sensor
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic select_n,
  input wire logic meas_reset,
  input wire logic osc_x,
  input wire logic osc_y,
  input wire logic osc_z,
  input wire logic fast_clock,
  output logic miso,
  output logic miso_oe_n,
  output logic result_ready,
  output logic fast_clock_test_out,
  output logic [1:0] osc_enable_axis,
  output logic osc_direction_rev,
  output logic osc_running,
  output logic low_power_idle
);
  import mgc_pkg::*;

  // one-bit period divider: true when selected count of edges done
  function automatic logic period_done(input logic [12:0] cnt, input logic [2:0] ps);
    period_done = (cnt == 13'((1 << (DIV_BASE_LOG2 + ps)) - 1));
  endfunction

  typedef struct packed {
    logic [2:0] sclk_s, mosi_s, sel_s, rst_s, osc_s, fck_s;
    mgc_state_t st;
    logic [7:0] cmd_sh;
    logic [2:0] bit_cnt;
    logic [7:0] cmd;
    logic [12:0] edges;
    logic [15:0] count;
    logic [15:0] fwd;
    logic [15:0] result;
    logic [4:0] out_cnt;
    logic miso_bit;
    logic ready;
    logic test_out;
    logic idle;
  } mgc_regs_t;

  mgc_regs_t r_r, r_nxt;
  logic sclk_rise, sclk_fall, sel_lo, osc_rise, fck_rise, rst_rise, osc_in;

  always_comb
  begin
    case (r_r.cmd[BIT_AXIS_HI:BIT_AXIS_LO])
      AXIS_X: osc_in = osc_x;
      AXIS_Y: osc_in = osc_y;
      AXIS_Z: osc_in = osc_z;
      default: osc_in = 1'b0;
    endcase
  end

  // edges detected only when second and third stages differ
  assign sclk_rise = r_r.sclk_s[1] & r_r.sclk_s[2] == 1'b0 ? r_r.sclk_s[1] : 1'b0;
  assign sclk_fall = (r_r.sclk_s[2] & ~r_r.sclk_s[1]);
  assign sel_lo = ~r_r.sel_s[2];
  assign osc_rise = r_r.osc_s[1] & ~r_r.osc_s[2];
  assign fck_rise = r_r.fck_s[1] & ~r_r.fck_s[2];
  assign rst_rise = r_r.rst_s[1] & ~r_r.rst_s[2];

  always_comb
  begin
    r_nxt = r_r;
    r_nxt.sclk_s = {r_r.sclk_s[1:0], sclk};
    r_nxt.mosi_s = {r_r.mosi_s[1:0], mosi};
    r_nxt.sel_s = {r_r.sel_s[1:0], select_n};
    r_nxt.rst_s = {r_r.rst_s[1:0], meas_reset};
    r_nxt.osc_s = {r_r.osc_s[1:0], osc_in};
    r_nxt.fck_s = {r_r.fck_s[1:0], fast_clock};
    if (fck_rise)
      r_nxt.test_out = ~r_r.test_out;
    if (rst_rise)
    begin
      // measurement reset pulse: clear command and ready RQ20
      r_nxt.st = ST_CMD;
      r_nxt.cmd = CMD_RESET; // RQ9
      r_nxt.bit_cnt = 3'h0;
      r_nxt.ready = 1'b0; // RQ20
      r_nxt.idle = 1'b0;
      r_nxt.out_cnt = 5'h0;
    end
    else
    begin
      case (r_r.st)
        ST_POWERUP:
          r_nxt.idle = 1'b0; // RQ3
        ST_CMD:
          if (sel_lo && sclk_rise)
          begin
            r_nxt.cmd_sh = {r_r.cmd_sh[6:0], r_r.mosi_s[2]}; // RQ2 RQ15
            r_nxt.bit_cnt = r_r.bit_cnt + 3'h1;
            if (r_r.bit_cnt == 3'h7)
            begin
              r_nxt.cmd = {r_r.cmd_sh[6:0], r_r.mosi_s[2]}; // RQ15
              r_nxt.edges = 13'h0;
              r_nxt.count = 16'h0;
              // axis 00 starts nothing RQ19
              if (r_r.cmd_sh[0] | r_r.mosi_s[2])
                r_nxt.st = ST_FWD; // RQ7
            end
          end
        ST_FWD, ST_REV:
          if (!r_r.cmd[BIT_OSC_TEST] && osc_rise) // RQ13
          begin
            r_nxt.count = r_r.count + 16'h1;
            r_nxt.edges = r_r.edges + 13'h1;
            if (period_done(r_r.edges, r_r.cmd[BIT_PS_HI:BIT_PS_LO])) // RQ11
            begin
              r_nxt.edges = 13'h0;
              r_nxt.count = 16'h0;
              if (r_r.st == ST_FWD)
              begin
                r_nxt.fwd = r_r.count + 16'h1;
                r_nxt.st = ST_REV;
              end
              else
              begin
                r_nxt.result = r_r.fwd - (r_r.count + 16'h1); // RQ8
                r_nxt.ready = 1'b1; // RQ6
                r_nxt.out_cnt = 5'h0;
                r_nxt.miso_bit = r_r.fwd[15] ^ 1'b0;
                r_nxt.st = ST_READY;
              end
            end
          end
        ST_READY:
        begin
          r_nxt.idle = ~sel_lo; // RQ3 RQ5
          if (sel_lo && sclk_fall && r_r.out_cnt < 5'd16) // RQ16
          begin
            r_nxt.out_cnt = r_r.out_cnt + 5'h1;
            r_nxt.result = {r_r.result[14:0], 1'b0};
          end
        end
        default:
          r_nxt.st = ST_POWERUP;
      endcase
    end
    r_nxt.miso_bit = r_nxt.result[15];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_r <= '0;
      r_r.st <= ST_POWERUP; // RQ3
    end
    else
      r_r <= r_nxt;
  end

  assign miso = r_r.ready ? r_r.miso_bit : 1'b0;
  assign miso_oe_n = r_r.sel_s[2]; // RQ18
  assign result_ready = r_r.ready; // RQ6 RQ19
  assign fast_clock_test_out = r_r.cmd[BIT_FAST_TEST] ? r_r.test_out : 1'b1; // RQ10
  assign osc_enable_axis = (r_r.st == ST_FWD || r_r.st == ST_REV) ?
    r_r.cmd[BIT_AXIS_HI:BIT_AXIS_LO] : 2'h0; // RQ14
  // direction honoured only in test run RQ12
  assign osc_direction_rev = r_r.cmd[BIT_OSC_TEST] ? r_r.cmd[BIT_DIR] : (r_r.st == ST_REV);
  assign osc_running = r_r.cmd[BIT_OSC_TEST]; // RQ13
  assign low_power_idle = r_r.idle; // RQ5
endmodule
`default_nettype wire

// ---- mgc_sensor_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module mgc_sensor_chk
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic select_n,
  input wire logic meas_reset,
  input wire logic miso_oe_n,
  input wire logic result_ready,
  input wire logic [1:0] osc_enable_axis,
  input wire logic osc_running,
  input wire logic low_power_idle
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_sel_hi; select_n [*6]; endsequence
  sequence s_sel_lo; !select_n [*6]; endsequence
  sequence s_quiet; !meas_reset && !$past(meas_reset, 6); endsequence
  property p_hiz; s_sel_hi |-> miso_oe_n; endproperty
  a_hiz: assert property (p_hiz) else $error("miso driven unselected");
  property p_oe; s_sel_lo |-> !miso_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("miso not driven");
  property p_idle; low_power_idle |-> result_ready || $past(result_ready); endproperty
  a_idle: assert property (p_idle) else $error("idle without ready");
  property p_sleep; (result_ready && select_n) [*6] |-> low_power_idle; endproperty
  a_sleep: assert property (p_sleep) else $error("no idle");
  property p_clr; $rose(meas_reset) |-> ##[2:8] !result_ready; endproperty
  a_clr: assert property (p_clr) else $error("ready not cleared");
  property p_hold; result_ready ##0 s_quiet |=> result_ready; endproperty
  a_hold: assert property (p_hold) else $error("ready dropped");
  property p_run; osc_running ##0 s_quiet |=> osc_running; endproperty
  a_run: assert property (p_run) else $error("test run stopped");
  property p_one; result_ready |-> osc_enable_axis == 2'h0; endproperty
  a_one: assert property (p_one) else $error("axis still on");
endmodule
bind mgc_sensor mgc_sensor_chk i_chk (.clk(clk), .rst_n(rst_n), .select_n(select_n),
  .meas_reset(meas_reset), .miso_oe_n(miso_oe_n), .result_ready(result_ready),
  .osc_enable_axis(osc_enable_axis), .osc_running(osc_running),
  .low_power_idle(low_power_idle));
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: %0h vs %0h", $time, a, e); end end
module testbench;
  import mgc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic osc_x = 1'b0;
  logic osc_y = 1'b0;
  logic osc_z = 1'b0;
  logic fck = 1'b0;
  logic sclk, mosi, select_n, meas_reset, miso, miso_oe_n, result_ready;
  logic fast_clock_test_out, osc_direction_rev, osc_running, low_power_idle;
  logic [1:0] osc_enable_axis;
  int num_errors = 0;
  int num_checks = 0;
  always #2.5 clk = ~clk;
  always #7 osc_x = ~osc_x;
  always #8 osc_y = ~osc_y;
  always #6 osc_z = ~osc_z;
  always #11 fck = ~fck;
  mgc_host i_host (.clk(clk), .miso(miso), .sclk(sclk), .mosi(mosi), .select_n(select_n),
    .meas_reset(meas_reset));
  mgc_sensor i_dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .mosi(mosi),
    .select_n(select_n), .meas_reset(meas_reset), .osc_x(osc_x), .osc_y(osc_y),
    .osc_z(osc_z), .fast_clock(fck), .miso(miso), .miso_oe_n(miso_oe_n),
    .result_ready(result_ready), .fast_clock_test_out(fast_clock_test_out),
    .osc_enable_axis(osc_enable_axis), .osc_direction_rev(osc_direction_rev),
    .osc_running(osc_running), .low_power_idle(low_power_idle));
  task automatic wait_ready(input int lim, input logic exp);
    int n;
    n = 0;
    while (result_ready !== 1'b1 && n < lim)
    begin
      i_host.tick(1);
      n++;
    end
    `CHK(result_ready, exp)
  endtask
  task automatic t_measure(input logic [7:0] cmd);
    logic [15:0] v;
    i_host.pulse_reset();
    `CHK(result_ready, 1'b0)
    i_host.send(cmd);
    `CHK(osc_enable_axis, cmd[1:0])
    `CHK(osc_direction_rev, 1'b0)
    wait_ready(30000, 1'b1);
    `CHK(miso_oe_n, 1'b0)
    i_host.read16(v);
    // steady oscillator: forward and reverse counts match, difference zero
    `CHK(v, 16'h0000)
    i_host.select_n = 1'b1;
    i_host.tick(8);
    `CHK(low_power_idle, 1'b1)
    `CHK(miso_oe_n, 1'b1)
  endtask
  task automatic t_test_run();
    int n;
    n = 0;
    i_host.pulse_reset();
    i_host.send(8'h86);
    `CHK(osc_running, 1'b1)
    `CHK(osc_direction_rev, 1'b0)
    repeat (40)
    begin
      i_host.tick(1);
      n += fast_clock_test_out;
    end
    `CHK(n > 0 && n < 40, 1'b1)
    `CHK(result_ready, 1'b0)
    i_host.pulse_reset();
    `CHK(osc_running, 1'b0)
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    i_host.tick(2);
    rst_n = 1'b1;
    i_host.tick(8);
    `CHK(result_ready | low_power_idle, 1'b0)
    `CHK(fast_clock_test_out, 1'b1)
    t_measure(8'h01);
    t_measure(8'h12);
    t_measure(8'h7B);
    i_host.pulse_reset();
    i_host.send(8'h70);
    wait_ready(2000, 1'b0);
    t_test_run();
    conclude();
  end
endmodule
`default_nettype wire
